/* logic/cgms_defs.vh */
// Purpose: constants for the clock generator mode selector
// Assumes: included by its bare name
// Notes: offsets are byte addresses on the plain register port
`ifndef CGMS_DEFS_VH
`define CGMS_DEFS_VH

// register offsets
`define CGMS_OFF_CTRL1   8'h00
`define CGMS_OFF_CTRL3   8'h04
`define CGMS_OFF_TEST    8'h08
`define CGMS_OFF_STATUS  8'h0c

// control 1 fields
`define CGMS_SRC_HI      7
`define CGMS_SRC_LO      6
`define CGMS_REFERENCE_DIVIDER_HI     5
`define CGMS_REFERENCE_DIVIDER_LO     3
`define CGMS_IREF_BIT    2
`define CGMS_LP_BIT      1
// control 3 fields
`define CGMS_LOOP_BIT    6
`define CGMS_EXTRA_REF_DIVIDE_BIT   4
`define CGMS_VCO_DIVIDER_HI     3
`define CGMS_VCO_DIVIDER_LO     0
// test register fields
`define CGMS_DMX_BIT     5
`define CGMS_DRS_BIT     0

// reset values
`define CGMS_CTRL1_RST   8'h04
`define CGMS_CTRL3_RST   8'h01
`define CGMS_TEST_RST    8'h00

// source select encodings
`define CGMS_SRC_LOOP    2'h0
`define CGMS_SRC_INT     2'h1
`define CGMS_SRC_EXT     2'h2

// output clock mux select
`define CGMS_MUX_FLL     2'h0
`define CGMS_MUX_PLL     2'h1
`define CGMS_MUX_INT     2'h2
`define CGMS_MUX_EXT     2'h3

// debug-link clock source
`define CGMS_LNK_NONE    2'h0
`define CGMS_LNK_FLL     2'h1
`define CGMS_LNK_DCO2    2'h2

// mode codes
`define CGMS_M_FEI       4'h0
`define CGMS_M_FEE       4'h1
`define CGMS_M_FBI       4'h2
`define CGMS_M_FBE       4'h3
`define CGMS_M_PEE       4'h4
`define CGMS_M_PBE       4'h5
`define CGMS_M_BYPASS_LOWPOWER_INTERNAL      4'h6
`define CGMS_M_BYPASS_LOWPOWER_EXTERNAL      4'h7
`define CGMS_M_STOP      4'h8

`endif

/* logic/cgms_mode_decode.v */
// Purpose: combinational decode of requested clock mode from control fields
// Assumes: inputs come straight from registers
// Notes: a field set outside any documented mode decodes as an invalid request
`timescale 1ns/1ns
`default_nettype none
`include "cgms_defs.vh"

module cgms_mode_decode (
	// control fields
	input  wire [1:0] clockSourceSelect,
	input  wire       internalRefSelect,
	input  wire       loopSelect,
	input  wire       lowPowerBit,
	// debug
	input  wire       debugActive,
	// decoded request
	output reg  [3:0] reqMode,
	output reg        reqValid
);

	// mode from field combination; debug forces low-power modes to bypassed
	always @* begin
		reqMode  = `CGMS_M_FEI;
		reqValid = 1'b0;
		case (clockSourceSelect)
			`CGMS_SRC_LOOP: begin
				reqValid = ~(internalRefSelect & loopSelect);
				if (internalRefSelect)
					reqMode = `CGMS_M_FEI;
				else if (loopSelect)
					reqMode = `CGMS_M_PEE;
				else
					reqMode = `CGMS_M_FEE;
			end
			`CGMS_SRC_INT: begin
				reqValid = internalRefSelect & ~loopSelect;
				if (lowPowerBit & ~debugActive)
					reqMode = `CGMS_M_BYPASS_LOWPOWER_INTERNAL;
				else
					reqMode = `CGMS_M_FBI;
			end
			`CGMS_SRC_EXT: begin
				reqValid = ~internalRefSelect;
				if (lowPowerBit & ~debugActive)
					reqMode = `CGMS_M_BYPASS_LOWPOWER_EXTERNAL;
				else if (loopSelect)
					reqMode = `CGMS_M_PBE;
				else
					reqMode = `CGMS_M_FBE;
			end
			default: begin
				reqValid = 1'b0;
			end
		endcase
	end

endmodule // cgms_mode_decode
`default_nettype wire

/* logic/cgms_mode_select.v */
// Function
// - default mode is fll engaged internal: source 00, internal ref 1, loop 0.
// - fll engaged internal drives output from fll on internal reference times dco factor.
// - source 00, internal ref 0, loop 0 gives fll engaged external; software divides reference.
// - fll engaged external drives output from fll locked to divided external reference.
// - source 01, internal ref 1, loop 0, low power 0 gives fll bypassed internal.
// - source 10, internal ref 0, loop 0, low power 0 gives fll bypassed external.
// - source 00, internal ref 0, loop 1 gives pll engaged external.
// - pll locks to divided reference times vco factor; engaged mode outputs pll.
// - pll modes: debug on gives dco divided by two link, else fll off.
// - source 10, internal ref 0, loop 1, low power 0 gives pll bypassed external.
// - dco range status reads zero in pll and both low-power modes.
// - source 01, internal ref 1, low power 1, no debug gives low-power internal.
// - debug active in low-power internal moves to fll bypassed internal.
// - source 10, internal ref 0, low power 1 gives low-power external, either loop.
// - nine-state mode machine allows only documented transitions.
// - fll modes derive link clock from fll and keep pll disabled.
// - debug active in low-power external moves to bypassed external by loop select.
// - dco range select writes ignored while low power or loop select set.
// - loop select 0 disables pll always; loop select 1 disables fll always.
//
// Purpose: mode selection logic of a multi-purpose clock generator
// Assumes: strobes one cycle, never both; read data valid the cycle after
// Notes: loops and clock muxes are analog/glitchless cells outside; this drives their selects
//   stop overrides any request; waking follows the pending request or falls back to fll engaged internal
//   a refused request holds the mode and keeps modeRefused high until software mends the fields
//   reference divider limits are software's duty; nothing here checks the divided frequency
//   range status reads through one register, standing in for the loop's clock domain crossing
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cgms_defs.vh"

module cgms_mode_select #(
	parameter ADDR_W = 8,
	parameter DATA_W = 8
) (
	// clock and reset
	input  wire              clk,
	input  wire              reset,
	// register port
	input  wire [ADDR_W-1:0] regAddr,
	input  wire [DATA_W-1:0] regWrData,
	input  wire              regWrite,
	input  wire              regRead,
	output reg  [DATA_W-1:0] regRdData,
	// chip context
	input  wire              debugActive,
	input  wire              stopRequest,
	// clock control
	output reg  [1:0]        mainClockMuxSel,
	output reg               fllEnable,
	output reg               pllEnable,
	output reg               fllOpenLoop,
	output reg  [1:0]        debugLinkSel,
	output reg  [3:0]        currentMode,
	output reg               modeRefused,
	// loop configuration
	output reg  [2:0]        referenceDivider,
	output reg               extraRefDivide,
	output reg  [3:0]        vcoDivider,
	output reg               dcoRangeSelect,
	output reg               dcoMaxFor32k,
	output reg               refSelectInternal
);

	// control 1 fields
	reg [1:0] srcSel_reg;
	reg [2:0] reference_divider_reg;
	reg       internal_ref_select_reg;
	reg       lp_reg;

	// control 3 fields
	reg       loop_reg;
	reg       extra_ref_divide_reg;
	reg [3:0] vco_divider_reg;

	// test register fields
	reg       dmx_reg;
	reg       drs_reg;
	reg       dco_range_status_reg;

	// mode machine
	reg [3:0] mode_reg;
	reg [3:0] mode_next;
	reg       refused_reg;
	reg       refused_next;

	// read path
	reg [DATA_W-1:0] rdData_next;

	// range status reads zero where the fll range is meaningless
	wire drstMasked = dco_range_status_reg &
		~((mode_reg == `CGMS_M_PEE) | (mode_reg == `CGMS_M_PBE) |
		  (mode_reg == `CGMS_M_BYPASS_LOWPOWER_INTERNAL) | (mode_reg == `CGMS_M_BYPASS_LOWPOWER_EXTERNAL));

	wire [3:0] reqMode;
	wire       reqValid;

	wire wrCtrl1 = regWrite & (regAddr == `CGMS_OFF_CTRL1);
	wire wrCtrl3 = regWrite & (regAddr == `CGMS_OFF_CTRL3);
	wire wrTest  = regWrite & (regAddr == `CGMS_OFF_TEST);

	// requested mode from registered fields
	cgms_mode_decode uDecode (
		.clockSourceSelect (srcSel_reg),
		.internalRefSelect (internal_ref_select_reg),
		.loopSelect        (loop_reg),
		.lowPowerBit       (lp_reg),
		.debugActive       (debugActive),
		.reqMode           (reqMode),
		.reqValid          (reqValid)
	);

	// software register writes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			srcSel_reg <= 2'h0;
			reference_divider_reg   <= 3'h0;
			internal_ref_select_reg  <= 1'h1;
			lp_reg     <= 1'h0;
			loop_reg   <= 1'h0;
			extra_ref_divide_reg  <= 1'h0;
			vco_divider_reg   <= 4'h1;
			dmx_reg    <= 1'h0;
			drs_reg    <= 1'h0;
		end else begin
			// source, divider, reference and low-power fields
			if (wrCtrl1) begin
				srcSel_reg <= regWrData[`CGMS_SRC_HI:`CGMS_SRC_LO];
				reference_divider_reg   <= regWrData[`CGMS_REFERENCE_DIVIDER_HI:`CGMS_REFERENCE_DIVIDER_LO];
				internal_ref_select_reg  <= regWrData[`CGMS_IREF_BIT];
				lp_reg     <= regWrData[`CGMS_LP_BIT];
			end
			// loop choice, extra divide and vco factor
			if (wrCtrl3) begin
				loop_reg <= regWrData[`CGMS_LOOP_BIT];
				// extra divide is an fll-only setting, frozen while the pll is chosen
				if (!loop_reg)
					extra_ref_divide_reg <= regWrData[`CGMS_EXTRA_REF_DIVIDE_BIT];
				vco_divider_reg <= regWrData[`CGMS_VCO_DIVIDER_HI:`CGMS_VCO_DIVIDER_LO];
			end
			// range select is locked while low power or loop select is set
			if (wrTest) begin
				dmx_reg <= regWrData[`CGMS_DMX_BIT];
				if (!(lp_reg | loop_reg))
					drs_reg <= regWrData[`CGMS_DRS_BIT];
			end
		end
	end

	// allowed moves of the nine-state machine; refused requests hold the mode
	function allowed;
		input [3:0] from;
		input [3:0] to;
		begin
			allowed = 1'b0;
			if (from == to)
				allowed = 1'b1;
			else
				case (from)
					// fll modes move freely among themselves
					`CGMS_M_FEI:  allowed = (to == `CGMS_M_FEE) |
					                        (to == `CGMS_M_FBI) |
					                        (to == `CGMS_M_FBE);
					`CGMS_M_FEE:  allowed = (to == `CGMS_M_FEI) |
					                        (to == `CGMS_M_FBI) |
					                        (to == `CGMS_M_FBE);
					`CGMS_M_FBI:  allowed = (to == `CGMS_M_FEI) |
					                        (to == `CGMS_M_FEE) |
					                        (to == `CGMS_M_FBE) |
					                        (to == `CGMS_M_BYPASS_LOWPOWER_INTERNAL);
					`CGMS_M_FBE:  allowed = (to == `CGMS_M_FEI) |
					                        (to == `CGMS_M_FEE) |
					                        (to == `CGMS_M_FBI) |
					                        (to == `CGMS_M_PBE) |
					                        (to == `CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
					// pll modes are reached only through the bypassed external one
					`CGMS_M_PBE:  allowed = (to == `CGMS_M_FBE) |
					                        (to == `CGMS_M_PEE) |
					                        (to == `CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
					`CGMS_M_PEE:  allowed = (to == `CGMS_M_PBE);
					// low-power modes leave only towards a bypassed mode
					`CGMS_M_BYPASS_LOWPOWER_INTERNAL: allowed = (to == `CGMS_M_FBI);
					`CGMS_M_BYPASS_LOWPOWER_EXTERNAL: allowed = (to == `CGMS_M_FBE) |
					                        (to == `CGMS_M_PBE);
					`CGMS_M_STOP: allowed = 1'b1; // wake returns to the requested mode
					default:      allowed = 1'b0;
				endcase
		end
	endfunction

	// next mode: stop overrides, else follow the request where the move is legal
	always @* begin
		mode_next    = mode_reg;
		refused_next = 1'b0;
		if (stopRequest) begin
			mode_next = `CGMS_M_STOP;
		end else if (reqValid && allowed(mode_reg, reqMode)) begin
			mode_next = reqMode;
		end else if (mode_reg == `CGMS_M_STOP) begin
			mode_next = `CGMS_M_FEI;
		end else begin
			refused_next = (reqMode != mode_reg) | ~reqValid;
		end
	end

	// mode register and range status; status lags the select one cycle like a sync
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg    <= `CGMS_M_FEI;
			refused_reg <= 1'b0;
			dco_range_status_reg    <= 1'b0;
		end else begin
			mode_reg    <= mode_next;
			refused_reg <= refused_next;
			dco_range_status_reg    <= drs_reg;
		end
	end

	// loop enables, output mux and link clock from the current mode
	always @* begin
		mainClockMuxSel = `CGMS_MUX_INT;
		fllEnable       = 1'b0;
		pllEnable       = 1'b0;
		fllOpenLoop     = 1'b0;
		debugLinkSel    = `CGMS_LNK_NONE;
		case (mode_reg)
			`CGMS_M_FEI, `CGMS_M_FEE: begin
				mainClockMuxSel = `CGMS_MUX_FLL;
				fllEnable       = 1'b1;
				debugLinkSel    = `CGMS_LNK_FLL;
			end
			// bypassed fll modes keep the fll locking behind the mux
			`CGMS_M_FBI: begin
				mainClockMuxSel = `CGMS_MUX_INT;
				fllEnable       = 1'b1;
				debugLinkSel    = `CGMS_LNK_FLL;
			end
			`CGMS_M_FBE: begin
				mainClockMuxSel = `CGMS_MUX_EXT;
				fllEnable       = 1'b1;
				debugLinkSel    = `CGMS_LNK_FLL;
			end
			// pll modes: the fll runs open loop only when debug needs a link clock
			`CGMS_M_PEE, `CGMS_M_PBE: begin
				mainClockMuxSel = (mode_reg == `CGMS_M_PEE) ? `CGMS_MUX_PLL : `CGMS_MUX_EXT;
				pllEnable       = 1'b1;
				// dco free-runs only to clock the debug link
				fllOpenLoop  = debugActive;
				debugLinkSel = debugActive ? `CGMS_LNK_DCO2 : `CGMS_LNK_NONE;
			end
			// low-power modes run no loop and give no link clock
			`CGMS_M_BYPASS_LOWPOWER_INTERNAL: begin
				mainClockMuxSel = `CGMS_MUX_INT;
			end
			`CGMS_M_BYPASS_LOWPOWER_EXTERNAL: begin
				mainClockMuxSel = `CGMS_MUX_EXT;
			end
			// stop keeps both loops off; the select rests on the internal reference
			`CGMS_M_STOP: begin
				mainClockMuxSel = `CGMS_MUX_INT;
			end
			default: begin
				mainClockMuxSel = `CGMS_MUX_INT;
			end
		endcase
		// loop select gates the unused loop in every mode
		if (loop_reg)
			fllEnable = 1'b0;
		else
			pllEnable = 1'b0;
	end

	// registered state and configuration outputs
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			currentMode       <= `CGMS_M_FEI;
			modeRefused       <= 1'b0;
			referenceDivider  <= 3'h0;
			extraRefDivide    <= 1'b0;
			vcoDivider        <= 4'h1;
			dcoRangeSelect    <= 1'b0;
			dcoMaxFor32k      <= 1'b0;
			refSelectInternal <= 1'b1;
		end else begin
			currentMode       <= mode_next;
			modeRefused       <= refused_next;
			referenceDivider  <= reference_divider_reg;
			extraRefDivide    <= extra_ref_divide_reg;
			vcoDivider        <= vco_divider_reg;
			dcoRangeSelect    <= drs_reg;
			dcoMaxFor32k      <= dmx_reg;
			refSelectInternal <= internal_ref_select_reg;
		end
	end

	// read mux; range status is forced low where the fll range is meaningless
	always @* begin
		rdData_next = {DATA_W{1'b0}};
		case (regAddr)
			`CGMS_OFF_CTRL1: begin
				rdData_next[`CGMS_SRC_HI:`CGMS_SRC_LO]   = srcSel_reg;
				rdData_next[`CGMS_REFERENCE_DIVIDER_HI:`CGMS_REFERENCE_DIVIDER_LO] = reference_divider_reg;
				rdData_next[`CGMS_IREF_BIT]              = internal_ref_select_reg;
				rdData_next[`CGMS_LP_BIT]                = lp_reg;
			end
			`CGMS_OFF_CTRL3: begin
				rdData_next[`CGMS_LOOP_BIT]              = loop_reg;
				rdData_next[`CGMS_EXTRA_REF_DIVIDE_BIT]             = extra_ref_divide_reg;
				rdData_next[`CGMS_VCO_DIVIDER_HI:`CGMS_VCO_DIVIDER_LO] = vco_divider_reg;
			end
			`CGMS_OFF_TEST: begin
				rdData_next[`CGMS_DMX_BIT] = dmx_reg;
				rdData_next[`CGMS_DRS_BIT] = drstMasked;
			end
			// status: current mode and the refusal flag
			`CGMS_OFF_STATUS: begin
				rdData_next[3:0] = mode_reg;
				rdData_next[4]   = refused_reg;
			end
			default: begin
				rdData_next = {DATA_W{1'b0}};
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk or posedge reset) begin
		if (reset)
			regRdData <= {DATA_W{1'b0}};
		else if (regRead)
			regRdData <= rdData_next;
		else
			regRdData <= {DATA_W{1'b0}};
	end

endmodule // cgms_mode_select
`default_nettype wire

/* test/cgms_debug_pod.sv */
// Purpose: debug controller that uses the generated link clock
// Assumes: shares the block's clock
// Notes: attach passes one sync stage, like a real pod request
`timescale 1ns/1ns
`default_nettype none
module cgms_debug_pod (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// bench side and link source
	input  wire logic       podAttach,
	input  wire logic [1:0] debugLinkSel,
	// to the block and bench
	output var  logic       debugActive,
	output wire logic       linkLost
);
	// debug activity follows the attach request one edge later
	always @(posedge clk or posedge reset) begin
		if (reset)
			debugActive <= 1'b0;
		else
			debugActive <= podAttach;
	end
	// no link while active would drop the session
	assign linkLost = debugActive && (debugLinkSel == 2'h0);
endmodule // cgms_debug_pod
`default_nettype wire

/* test/cgms_mode_select_bench.sv */
// Purpose: self-checking bench for the clock mode selector
// Assumes: mode follows a control write by one edge
// Notes: divider fields random, mode path hand-picked along allowed moves
`timescale 1ns/1ns
`default_nettype none
`include "cgms_defs.vh"
module cgms_mode_select_bench;
	logic       clk, reset, regWrite, regRead, stopRequest, podAttach, debugActive, linkLost;
	logic       fllEnable, pllEnable, fllOpenLoop, modeRefused, dcoRangeSelect;
	logic       extraRefDivide, dcoMaxFor32k, refSelectInternal;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [1:0] mainClockMuxSel, debugLinkSel;
	logic [3:0] currentMode, vcoDivider, vdv;
	logic [2:0] referenceDivider, rdv;
	int         errors = 0, samples_checked = 0;
	cgms_mode_select u_cgms_mode_select (.clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .debugActive, .stopRequest, .mainClockMuxSel, .fllEnable, .pllEnable,
		.fllOpenLoop, .debugLinkSel, .currentMode, .modeRefused, .referenceDivider,
		.extraRefDivide, .vcoDivider, .dcoRangeSelect, .dcoMaxFor32k, .refSelectInternal);
	cgms_debug_pod u_cgms_debug_pod (.clk, .reset, .podAttach, .debugLinkSel, .debugActive, .linkLost);
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// expected {mux, fll, pll, link} for a mode
	function automatic [5:0] ctl(input [3:0] m, input dbg);
		case (m)
			4'h0, 4'h1: ctl = {2'h0, 2'b10, 2'h1};
			4'h2: ctl = {2'h2, 2'b10, 2'h1};
			4'h3: ctl = {2'h3, 2'b10, 2'h1};
			4'h4: ctl = {2'h1, 2'b01, dbg, 1'b0};
			4'h5: ctl = {2'h3, 2'b01, dbg, 1'b0};
			4'h6: ctl = {2'h2, 2'b00, 2'h0};
			default: ctl = {2'h3, 2'b00, 2'h0};
		endcase
	endfunction
	task automatic chk(input [7:0] got, input [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input [7:0] a, input [7:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdData, e);
		@(posedge clk);
	endtask
	// wait for the mode to follow, then check every control except in stop
	task automatic expm(input [3:0] m);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(currentMode, m);
		if (m != `CGMS_M_STOP)
			chk(ctl(m, debugActive), {mainClockMuxSel, fllEnable, pllEnable, debugLinkSel});
		chk(linkLost, 1'b0);
		@(posedge clk);
	endtask
	task automatic go(input [1:0] src, input iref, input lp, input [3:0] m);
		rdv = 3'($urandom);
		wr(`CGMS_OFF_CTRL1, {src, rdv, iref, lp, 1'b0});
		expm(m);
		chk(referenceDivider, rdv);
		chk(refSelectInternal, iref);
	endtask
	task automatic dbg(input on, input [3:0] m);
		podAttach <= on;
		expm(m);
	endtask
	// range select write, then status and copy
	task automatic dco_range_select(input [3:0] m, input e);
		wr(`CGMS_OFF_TEST, 8'h01);
		expm(m);
		rd(`CGMS_OFF_TEST, {7'h0, e});
		chk(dcoRangeSelect, e);
	endtask
	task automatic print_verdict;
		$display("checked=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, far beyond the roughly 125 cycles used
	initial begin
		#1000000;
		errors++;
		print_verdict;
	end
	initial begin
		reset = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		stopRequest = 1'b0;
		podAttach = 1'b0;
		rdv = 3'($urandom(57));
		vdv = 4'($urandom_range(10, 1));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(`CGMS_OFF_CTRL1, `CGMS_CTRL1_RST);
		rd(`CGMS_OFF_CTRL3, `CGMS_CTRL3_RST);
		rd(`CGMS_OFF_TEST, `CGMS_TEST_RST);
		rd(8'h10, 8'h00);
		expm(`CGMS_M_FEI);
		go(2'h0, 1'b0, 1'b0, `CGMS_M_FEE);
		go(2'h1, 1'b1, 1'b0, `CGMS_M_FBI);
		go(2'h1, 1'b1, 1'b1, `CGMS_M_BYPASS_LOWPOWER_INTERNAL);
		dbg(1'b1, `CGMS_M_FBI);
		dbg(1'b0, `CGMS_M_BYPASS_LOWPOWER_INTERNAL);
		dco_range_select(`CGMS_M_BYPASS_LOWPOWER_INTERNAL, 1'b0);
		go(2'h1, 1'b1, 1'b0, `CGMS_M_FBI);
		go(2'h2, 1'b0, 1'b0, `CGMS_M_FBE);
		go(2'h2, 1'b0, 1'b1, `CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
		dbg(1'b1, `CGMS_M_FBE);
		dbg(1'b0, `CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
		wr(`CGMS_OFF_CTRL3, {4'h4, vdv});
		expm(`CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
		chk(vcoDivider, vdv);
		dbg(1'b1, `CGMS_M_PBE);
		chk(fllOpenLoop, 1'b1);
		dbg(1'b0, `CGMS_M_BYPASS_LOWPOWER_EXTERNAL);
		go(2'h2, 1'b0, 1'b0, `CGMS_M_PBE);
		go(2'h0, 1'b0, 1'b0, `CGMS_M_PEE);
		dco_range_select(`CGMS_M_PEE, 1'b0);
		dbg(1'b1, `CGMS_M_PEE);
		dbg(1'b0, `CGMS_M_PEE);
		go(2'h3, 1'b0, 1'b0, `CGMS_M_PEE);
		chk(modeRefused, 1'b1);
		go(2'h2, 1'b0, 1'b0, `CGMS_M_PBE);
		wr(`CGMS_OFF_CTRL3, 8'h01);
		expm(`CGMS_M_FBE);
		go(2'h0, 1'b1, 1'b0, `CGMS_M_FEI);
		dco_range_select(`CGMS_M_FEI, 1'b1);
		chk(dcoMaxFor32k, 1'b0);
		wr(`CGMS_OFF_TEST, 8'h21);
		expm(`CGMS_M_FEI);
		wr(`CGMS_OFF_CTRL3, 8'h11);
		expm(`CGMS_M_FEI);
		chk(extraRefDivide, 1'b1);
		chk(dcoMaxFor32k, 1'b1);
		stopRequest <= 1'b1;
		expm(`CGMS_M_STOP);
		stopRequest <= 1'b0;
		expm(`CGMS_M_FEI);
		print_verdict;
	end
endmodule // cgms_mode_select_bench
`default_nettype wire

/* test/cgms_mode_select_sva.sv */
// Purpose: port-level checks for the clock mode selector
// Assumes: mode codes and mux codes of the defines header
// Notes: mode follows a control write by one edge, so guards skip writes
`timescale 1ns/1ns
`default_nettype none
module cgms_mode_select_sva (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	// chip context
	input wire logic       debugActive,
	input wire logic       stopRequest,
	// clock control
	input wire logic [1:0] mainClockMuxSel,
	input wire logic       fllEnable,
	input wire logic       pllEnable,
	input wire logic [1:0] debugLinkSel,
	input wire logic [3:0] currentMode,
	input wire logic       modeRefused,
	input wire logic       dcoRangeSelect
);
	// pll or low-power modes, where loop select or low power is set
	wire lpPll = (currentMode >= 4'h4) && (currentMode <= 4'h7);
	wire pllMd = (currentMode == 4'h4) || (currentMode == 4'h5);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_fll_mux_out:
		assert property (currentMode <= 4'h1 |-> mainClockMuxSel == 2'h0)
		else $error("engaged fll mode without fll mux");
	a_int_mux_out:
		assert property (currentMode == 4'h2 || currentMode == 4'h6 |-> mainClockMuxSel == 2'h2)
		else $error("internal bypass without internal mux");
	a_ext_mux_out:
		assert property (currentMode == 4'h3 || currentMode == 4'h5 || currentMode == 4'h7
			|-> mainClockMuxSel == 2'h3)
		else $error("external bypass without external mux");
	a_pee_pll_out:
		assert property (currentMode == 4'h4 |-> mainClockMuxSel == 2'h1 && pllEnable && !fllEnable)
		else $error("pll engaged controls wrong");
	a_fll_link_src:
		assert property (currentMode < 4'h4 |-> debugLinkSel == 2'h1 && fllEnable && !pllEnable)
		else $error("fll mode link or loop enables wrong");
	a_pll_link_src:
		assert property (pllMd |-> !fllEnable && debugLinkSel == {debugActive, 1'b0})
		else $error("pll mode link source wrong");
	a_lp_loops_off:
		assert property (currentMode == 4'h6 || currentMode == 4'h7
			|-> !fllEnable && !pllEnable && debugLinkSel == 2'h0)
		else $error("low-power mode with a loop running");
	a_lpi_debug_exit:
		assert property (currentMode == 4'h6 && debugActive && !stopRequest && !$past(regWrite)
			|=> currentMode == 4'h2)
		else $error("debug did not leave low-power internal");
	a_lpe_debug_exit:
		assert property (currentMode == 4'h7 && debugActive && !stopRequest && !$past(regWrite)
			|=> currentMode == 4'h3 || currentMode == 4'h5)
		else $error("debug did not leave low-power external");
	a_refuse_hold:
		assert property (modeRefused && !$past(stopRequest) |-> $stable(currentMode))
		else $error("mode moved on a refused request");
	a_status_zero:
		assert property (regRead && regAddr == 8'h08 && lpPll ##1 lpPll |-> regRdData[0] == 1'b0)
		else $error("range status not zero");
	a_range_lock:
		assert property (regWrite && regAddr == 8'h08 && lpPll && !$past(regWrite)
			|=> ##1 $stable(dcoRangeSelect))
		else $error("range select written while locked");
endmodule // cgms_mode_select_sva
bind cgms_mode_select cgms_mode_select_sva u_cgms_mode_select_sva (.clk, .reset, .regAddr,
	.regWrite, .regRead, .regRdData, .debugActive, .stopRequest, .mainClockMuxSel, .fllEnable,
	.pllEnable, .debugLinkSel, .currentMode, .modeRefused, .dcoRangeSelect);
`default_nettype wire
